// [hw/fah_host.sv]
// Host controller that reads autoselect codes and drives protect cycles.

// Operation
// R01: Autoselect returns maker, part, continuation, protection codes.
// R02: High voltage on ninth line during reads.
// R03: A6 low; A1 and A0 select code.
// R04: Sector select bits choose sector; 01h protected.
// R05: Codes also available via command sequence.
// R06: Protected sector refuses program and erase.
// R07: Unprotect restores program and erase.
// R08: Protect method: high voltage on reset only.
// R09: Protect all sectors before first unprotect.
// R10: Alternate method only for programming equipment.
// R11: Sectors start unprotected.
// R12: Program or erase needs full unlock sequence.
// R13: Power-up leaves device in array read.
// R14: Pulses under 5ns start no write.
// R15: No write while gate low or selects high.
// R16: Write: select and strobe low, gate high.
// R17: No command accepted after power-up strobe.
// R18: Reset high voltage unprotects temporarily.
// R19: Removing high voltage returns to array reads.
module fah_host (
  input wire logic ref_clk_i,                      // 125 MHz clock.
  input wire logic rst_n_i,                        // Async reset, low.
  input wire logic req_i,                          // Request, one cycle.
  input wire fah_pkg::fah_op_t op_i,               // Requested operation.
  input wire logic [1:0] code_sel_i,               // Code select.
  input wire logic [fah_pkg::SECT_W-1:0] sector_i, // Sector select.
  input wire logic [fah_pkg::ADDR_W-1:0] wr_addr_i, // Protect write addr.
  input wire logic [7:0] wr_data_i,                // Protect write data.
  input wire logic [fah_pkg::SECT_W-1:0] stat_addr_i, // Table read addr.
  output logic stat_prot_o,                        // Table read flag.
  output logic busy_o,                             // Operation running.
  output logic done_o,                             // Operation end pulse.
  output logic refused_o,                          // Refusal pulse.
  output logic [7:0] rdata_o,                      // Last code read.
  output logic all_prot_o,                         // Last scan all 01h, cleared by unprotect.
  output logic ce_n_o,                             // Chip select, low.
  output logic oe_n_o,                             // Output gate, low.
  output logic we_n_o,                             // Write strobe, low.
  output logic [fah_pkg::ADDR_W-1:0] addr_o,       // Address pins.
  input wire logic [fah_pkg::DQ_W-1:0] dq_i,       // Data pins in.
  output logic [fah_pkg::DQ_W-1:0] dq_o,           // Data pins out.
  output logic dq_oe_n_o,                          // Data drive, low.
  output logic a9_hv_o,                            // Ninth line high volt.
  output logic rst_hv_o                            // Reset pin high volt.
);

  // ---------------------------------------------------------------------
  // Data pin synchroniser.
  // ---------------------------------------------------------------------
  logic [fah_pkg::DQ_W-1:0] dq_s1_r; // First stage, read only by second.
  logic [fah_pkg::DQ_W-1:0] dq_s2_r; // Second stage, safe to read.

  // The flash answers asynchronously, so data pass two flip-flops.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ---------------------------------------------------------------------
  // Control state.
  // ---------------------------------------------------------------------
  fah_pkg::fah_state_t state_r, state_nxt; // Sequencer state.
  fah_pkg::fah_op_t op_r, op_nxt;          // Operation in progress.
  logic [1:0] code_r, code_nxt;            // Latched code select.
  logic [fah_pkg::SECT_W-1:0] sect_r, sect_nxt; // Latched sector.
  logic [fah_pkg::ADDR_W-1:0] waddr_r, waddr_nxt; // Latched write addr.
  logic [7:0] wdata_r, wdata_nxt;          // Latched write data.
  logic [fah_pkg::STEP_W-1:0] step_r, step_nxt; // Bus cycle index.
  logic [fah_pkg::CNT_W-1:0] cnt_r, cnt_nxt; // Cycle counter.
  logic acc_r, acc_nxt;                    // Scan: all protected so far.
  logic all_prot_r, all_prot_nxt;          // Result of last full scan, cleared by unprotect.
  logic done_r, done_nxt;
  logic refused_r, refused_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic a9_hv_r, a9_hv_nxt;
  logic rst_hv_r, rst_hv_nxt;
  logic ce_n_r, ce_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic we_n_r, we_n_nxt;
  logic [fah_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [fah_pkg::DQ_W-1:0] dq_r, dq_nxt;
  logic dq_oe_n_r, dq_oe_n_nxt;
  logic mem_we;                            // Table write strobe.

  // Decode of the current step: write or read, address and data.
  logic step_wr;
  logic step_last;
  logic [fah_pkg::ADDR_W-1:0] step_addr;
  logic [7:0] step_data;

  // ---------------------------------------------------------------------
  // Step decode.
  // ---------------------------------------------------------------------
  // Every code read keeps A6 low and puts the code on A1 and A0; the
  // sector select bits sit on the top address lines.
  always_comb begin
    step_wr = 1'b0;
    step_data = fah_pkg::RESET_DATA;
    step_addr = '0;
    step_addr[fah_pkg::SECT_LSB +: fah_pkg::SECT_W] = sect_r; // [R04]
    step_addr[fah_pkg::A6_POS] = 1'b0; // [R03]
    step_addr[1:0] = code_r; // [R03]
    step_last = (step_r == '0);
    unique case (op_r)
      fah_pkg::FAH_OP_HV_READ: begin
      end
      fah_pkg::FAH_OP_SCAN: begin
        // Scan walks every sector select value reading protection.
        step_addr[fah_pkg::SECT_LSB +: fah_pkg::SECT_W] =
          step_r[fah_pkg::SECT_W-1:0]; // [R04]
        step_addr[1:0] = fah_pkg::CODE_PROT; // [R04]
        step_last = (step_r == fah_pkg::SCAN_LAST_STEP);
      end
      fah_pkg::FAH_OP_SYS_READ: begin
        // Unlock, autoselect command, read, then reset back to array.
        step_last = (step_r == fah_pkg::SYS_LAST_STEP); // [R05]
        if (step_r == '0) begin
          step_wr = 1'b1;
          step_addr = fah_pkg::UNLOCK1_ADDR;
          step_data = fah_pkg::UNLOCK1_DATA;
        end else if (step_r == 10'h001) begin
          step_wr = 1'b1;
          step_addr = fah_pkg::UNLOCK2_ADDR;
          step_data = fah_pkg::UNLOCK2_DATA;
        end else if (step_r == 10'h002) begin
          step_wr = 1'b1;
          step_addr = fah_pkg::UNLOCK1_ADDR;
          step_data = fah_pkg::AUTOSEL_DATA;
        end else if (step_r != fah_pkg::SYS_READ_STEP) begin
          step_wr = 1'b1;
          step_addr = '0;
        end
      end
      default: begin
        // Protect and unprotect cycles use the caller's address and data.
        step_wr = 1'b1;
        step_addr = waddr_r;
        step_data = wdata_r;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Sequencer next state.
  // ---------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    code_nxt = code_r;
    sect_nxt = sect_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    all_prot_nxt = all_prot_r;
    done_nxt = 1'b0;
    refused_nxt = 1'b0;
    rdata_nxt = rdata_r;
    a9_hv_nxt = a9_hv_r;
    rst_hv_nxt = rst_hv_r;
    mem_we = 1'b0;
    unique case (state_r)
      fah_pkg::FAH_IDLE: begin
        if (req_i) begin
          op_nxt = op_i;
          code_nxt = code_sel_i;
          sect_nxt = sector_i;
          waddr_nxt = wr_addr_i;
          wdata_nxt = wr_data_i;
          step_nxt = '0;
          cnt_nxt = fah_pkg::CNT_W'(fah_pkg::VID_CYC);
          if (op_i == fah_pkg::FAH_OP_UNPROT_WR && !all_prot_r) begin
            // Unprotect only after a scan has seen every sector locked.
            refused_nxt = 1'b1; // [R09]
          end else if (op_i == fah_pkg::FAH_OP_SYS_READ) begin
            state_nxt = fah_pkg::FAH_SETUP; // [R05]
          end else if (op_i == fah_pkg::FAH_OP_HV_READ ||
                       op_i == fah_pkg::FAH_OP_SCAN) begin
            a9_hv_nxt = 1'b1; // [R02]
            acc_nxt = 1'b1;
            state_nxt = fah_pkg::FAH_SETTLE;
          end else begin
            // Protect cycles raise the reset pin only, never the address.
            rst_hv_nxt = 1'b1; // [R08]
            state_nxt = fah_pkg::FAH_SETTLE;
          end
        end
      end
      fah_pkg::FAH_SETTLE: begin
        // Wait for the high voltage to settle before the first strobe.
        if (cnt_r == '0) begin
          state_nxt = fah_pkg::FAH_SETUP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      fah_pkg::FAH_SETUP: begin
        // Address settles one cycle ahead of the strobe.
        state_nxt = fah_pkg::FAH_STROBE;
        cnt_nxt = step_wr ? fah_pkg::CNT_W'(fah_pkg::STROBE_CYC) :
          fah_pkg::CNT_W'(fah_pkg::STROBE_CYC + fah_pkg::SYNC_CYC);
      end
      fah_pkg::FAH_STROBE: begin
        if (cnt_r == '0) begin
          state_nxt = fah_pkg::FAH_HOLD;
          if (!step_wr) begin
            // Data have crossed the synchroniser while the gate is low.
            rdata_nxt = dq_s2_r[7:0]; // [R01]
            mem_we = (op_r == fah_pkg::FAH_OP_SCAN);
            acc_nxt = acc_r && (dq_s2_r[7:0] == fah_pkg::PROT_YES);
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      fah_pkg::FAH_HOLD: begin
        if (step_last) begin
          state_nxt = fah_pkg::FAH_IDLE;
          done_nxt = 1'b1;
          // Dropping the high voltage returns the part to array reads.
          a9_hv_nxt = 1'b0; // [R19]
          rst_hv_nxt = 1'b0;
          if (op_r == fah_pkg::FAH_OP_SCAN) begin
            all_prot_nxt = acc_r;
          end else if (op_r == fah_pkg::FAH_OP_UNPROT_WR) begin
            all_prot_nxt = 1'b0;
          end
        end else begin
          step_nxt = step_r + 1'b1;
          state_nxt = fah_pkg::FAH_SETUP;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Pin next values.
  // ---------------------------------------------------------------------
  // Strobes go low one cycle after the counter starts, so the address is
  // stable first and each low time is whole cycles, far above 5ns.
  always_comb begin
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    if (state_r == fah_pkg::FAH_SETUP) begin
      addr_nxt = step_addr;
      dq_nxt = {8'h00, step_data};
    end
    ce_n_nxt = !(state_r == fah_pkg::FAH_SETUP ||
                 state_r == fah_pkg::FAH_STROBE ||
                 state_r == fah_pkg::FAH_HOLD);
    // Write strobe only with the gate high and the chip selected.
    we_n_nxt = !(state_r == fah_pkg::FAH_STROBE && cnt_r != '0 &&
                 step_wr); // [R16]
    oe_n_nxt = !(state_r == fah_pkg::FAH_STROBE && cnt_r != '0 &&
                 !step_wr);
    dq_oe_n_nxt = !(step_wr && !ce_n_nxt);
  end

  // Register every piece of control state and every pin.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= fah_pkg::FAH_IDLE;
      op_r <= fah_pkg::FAH_OP_HV_READ;
      code_r <= fah_pkg::CODE_MAKER;
      sect_r <= '0;
      waddr_r <= '0;
      wdata_r <= '0;
      step_r <= '0;
      cnt_r <= '0;
      acc_r <= 1'b0;
      all_prot_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      rdata_r <= '0;
      a9_hv_r <= 1'b0;
      rst_hv_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      addr_r <= '0;
      dq_r <= '0;
      dq_oe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      code_r <= code_nxt;
      sect_r <= sect_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      all_prot_r <= all_prot_nxt;
      done_r <= done_nxt;
      refused_r <= refused_nxt;
      rdata_r <= rdata_nxt;
      a9_hv_r <= a9_hv_nxt;
      rst_hv_r <= rst_hv_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Protection table.
  // ---------------------------------------------------------------------
  fah_sect_mem #(
    .AW(fah_pkg::SECT_W)
  ) u_sect_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(mem_we),
    .wr_addr_i(step_r[fah_pkg::SECT_W-1:0]),
    .wr_data_i(dq_s2_r[0]),
    .rd_addr_i(stat_addr_i),
    .rd_data_o(stat_prot_o)
  );

  assign busy_o = (state_r != fah_pkg::FAH_IDLE);
  assign done_o = done_r;
  assign refused_o = refused_r;
  assign rdata_o = rdata_r;
  assign all_prot_o = all_prot_r;
  assign ce_n_o = ce_n_r;
  assign oe_n_o = oe_n_r;
  assign we_n_o = we_n_r;
  assign addr_o = addr_r;
  assign dq_o = dq_r;
  assign dq_oe_n_o = dq_oe_n_r;
  assign a9_hv_o = a9_hv_r;
  assign rst_hv_o = rst_hv_r;

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  // Every check below runs on the one clock and sleeps during reset.
  default clocking cb_main @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_hv_on_read;
    (!oe_n_o && op_r != fah_pkg::FAH_OP_SYS_READ) |-> a9_hv_o;
  endproperty
  a_hv_on_read: assert property (p_hv_on_read) // [R02]
    else $error("Code read without high voltage on ninth line.");

  property p_a6_low;
    (!oe_n_o && a9_hv_o) |-> !addr_o[fah_pkg::A6_POS];
  endproperty
  a_a6_low: assert property (p_a6_low) // [R03]
    else $error("A6 high during autoselect read.");

  property p_code_sel;
    (!oe_n_o && op_r == fah_pkg::FAH_OP_HV_READ) |->
      addr_o[1:0] == $past(code_r, 2);
  endproperty
  a_code_sel: assert property (p_code_sel) // [R03]
    else $error("Code select bits do not match request.");

  property p_reset_hv_only;
    (!we_n_o && (op_r == fah_pkg::FAH_OP_PROT_WR ||
                 op_r == fah_pkg::FAH_OP_UNPROT_WR)) |->
      rst_hv_o && !a9_hv_o;
  endproperty
  a_reset_hv_only: assert property (p_reset_hv_only) // [R08]
    else $error("Protect cycle without reset-only high voltage.");

  property p_unprot_refused;
    (req_i && !busy_o && op_i == fah_pkg::FAH_OP_UNPROT_WR &&
     !all_prot_o) |=> refused_o ##1 (!busy_o && we_n_o);
  endproperty
  a_unprot_refused: assert property (p_unprot_refused) // [R09]
    else $error("Unprotect started without all sectors protected.");

  property p_no_alt_write;
    a9_hv_o |-> we_n_o;
  endproperty
  a_no_alt_write: assert property (p_no_alt_write) // [R10]
    else $error("Write strobe with high voltage on ninth line.");

  property p_write_form;
    !we_n_o |-> (!ce_n_o && oe_n_o && !dq_oe_n_o);
  endproperty
  a_write_form: assert property (p_write_form) // [R16]
    else $error("Write strobe without select low and gate high.");

  property p_we_width;
    $fell(we_n_o) |-> (!we_n_o)[*5] ##1 we_n_o;
  endproperty
  a_we_width: assert property (p_we_width) // [R16]
    else $error("Write strobe low time is not five cycles.");

  c_hv_read: cover property (done_o && op_r == fah_pkg::FAH_OP_HV_READ);
  c_sys_read: cover property (done_o && op_r == fah_pkg::FAH_OP_SYS_READ);
  c_scan_all: cover property ($rose(all_prot_o));
  c_refused: cover property (refused_o);

endmodule

// [hw/fah_pkg.sv]
// Shared constants and types of the flash autoselect and protect host.
package fah_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing.
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;     // Period of ref_clk_i.
  localparam int T_STROBE_NS = 40;      // Least low time of a strobe.
  localparam int STROBE_CYC =
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_VID_SETTLE_NS = 1000; // High voltage settle time.
  localparam int VID_CYC =
    (T_VID_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;          // Depth of the data synchroniser.

  // ---------------------------------------------------------------------
  // Pin geometry.
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 21;           // Word mode address width.
  localparam int DQ_W = 16;             // Data pins.
  localparam int SECT_W = 9;            // Sector select address width.
  localparam int SECT_LSB = 12;         // Lowest sector select bit.
  localparam int A6_POS = 6;            // Address bit held low for codes.
  localparam int STEP_W = 10;           // Width of the step counter.
  localparam int CNT_W = 8;             // Width of the cycle counter.

  // ---------------------------------------------------------------------
  // Autoselect code selection on address bits 1 and 0.
  // ---------------------------------------------------------------------
  localparam logic [1:0] CODE_MAKER = 2'h0;
  localparam logic [1:0] CODE_PART = 2'h1;
  localparam logic [1:0] CODE_PROT = 2'h2;
  localparam logic [1:0] CODE_CONT = 2'h3;
  localparam logic [7:0] PROT_YES = 8'h01; // Sector is protected.
  localparam logic [7:0] PROT_NO = 8'h00;  // Sector is unprotected.

  // ---------------------------------------------------------------------
  // In-system autoselect command sequence.
  // ---------------------------------------------------------------------
  localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h0002aa;
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] AUTOSEL_DATA = 8'h90;
  localparam logic [7:0] RESET_DATA = 8'hf0;
  localparam logic [9:0] SYS_READ_STEP = 10'h003; // Read step of sequence.
  localparam logic [9:0] SYS_LAST_STEP = 10'h004; // Closing reset write.
  localparam logic [9:0] SCAN_LAST_STEP = 10'h1ff; // Last sector scanned.

  // ---------------------------------------------------------------------
  // Operations and states.
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    FAH_OP_HV_READ,    // Code read with high voltage on the ninth line.
    FAH_OP_SYS_READ,   // Code read through the command sequence.
    FAH_OP_SCAN,       // Protection read of every sector select value.
    FAH_OP_PROT_WR,    // Protect write cycle, high voltage on reset.
    FAH_OP_UNPROT_WR   // Unprotect write cycle, high voltage on reset.
  } fah_op_t;

  typedef enum logic [2:0] {
    FAH_IDLE,
    FAH_SETTLE,
    FAH_SETUP,
    FAH_STROBE,
    FAH_HOLD
  } fah_state_t;

endpackage

// [hw/fah_sect_mem.sv]
// One bit per sector select value: the protection status read by the last scan.
module fah_sect_mem #(
  parameter int AW = 9                  // Address width.
) (
  input wire logic ref_clk_i,           // Clock.
  input wire logic wr_en_i,             // Write strobe.
  input wire logic [AW-1:0] wr_addr_i,  // Write address.
  input wire logic wr_data_i,           // Protected flag to store.
  input wire logic [AW-1:0] rd_addr_i,  // Read address.
  output logic rd_data_o                // Registered read data.
);

  // ---------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------
  // No reset on the array so that it maps onto memory; a read before
  // the first scan returns an undefined flag.
  logic mem_r [0:(1 << AW)-1];

  // Write and registered read in one clocked process.
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule

// [bench/fah_flash_model.sv]
// Behavioural flash device that answers autoselect and protect cycles.
module fah_flash_model #(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary maker code.
  parameter logic [7:0] PART = 8'h3c,  // Arbitrary part code.
  parameter logic [7:0] CONT = 8'hc3   // Arbitrary continuation code.
) (
  input wire logic ce_n_i,        // Chip select, low.
  input wire logic oe_n_i,        // Output gate, low.
  input wire logic we_n_i,        // Write strobe, low.
  input wire logic [20:0] addr_i, // Address pins.
  input wire logic [15:0] dq_i,   // Data from the host.
  input wire logic a9_hv_i,       // High voltage on the ninth line.
  input wire logic rst_hv_i,      // High voltage on the reset pin.
  output logic [15:0] dq_o        // Data to the host.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prot [512];  // One protect bit per sector select value.
  logic [1:0] step;  // Progress through the unlock writes.
  logic autosel;     // In-system autoselect entered.
  logic [15:0] last; // Last value put on the bus.
  logic [15:0] val;  // Value for the present address.
  realtime t_fall;   // Time of the last strobe fall.
  initial begin
    foreach (prot[i]) prot[i] = 1'b0;
    step = 2'h0;
    autosel = 1'b0;
    last = 16'h0000;
    t_fall = 0.0;
  end
  // ---------------------------------------------------------------
  // Read side.
  // ---------------------------------------------------------------
  // Outside autoselect, or with A6 high, plain array data answers.
  always @* begin
    val = 16'hffff;
    if ((a9_hv_i || autosel) && !addr_i[6]) begin
      case (addr_i[1:0])
        2'h0: val = {8'h00, MAKER};
        2'h1: val = {8'h00, PART};
        2'h3: val = {8'h00, CONT};
        default: val = {15'h0000, prot[addr_i[20:12]]};
      endcase
    end
  end
  // A released bus shows the inverse, so late sampling fails.
  always @* begin
    if (!ce_n_i && !oe_n_i) begin
      dq_o = val;
      last = val;
    end else begin
      dq_o = ~last;
    end
  end
  // ---------------------------------------------------------------
  // Write side.
  // ---------------------------------------------------------------
  always @(negedge we_n_i) t_fall = $realtime;
  // A write counts only at a strobe rise with gate high and select low.
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && $realtime - t_fall >= 5.0) begin
      if (rst_hv_i) begin
        if (dq_i[0]) begin
          prot[addr_i[20:12]] = 1'b1;
        end else begin
          foreach (prot[i]) prot[i] = 1'b0;
        end
      end else if (dq_i[7:0] == 8'hf0) begin
        autosel = 1'b0;
        step = 2'h0;
      end else if (step == 2'h0 && addr_i == 'h555 && dq_i[7:0] == 8'haa) begin
        step = 2'h1;
      end else if (step == 2'h1 && addr_i == 'h2aa && dq_i[7:0] == 8'h55) begin
        step = 2'h2;
      end else if (step == 2'h2 && addr_i == 'h555 && dq_i[7:0] == 8'h90) begin
        autosel = 1'b1;
        step = 2'h0;
      end else begin
        step = 2'h0;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the autoselect and protect host.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary maker code.
  localparam logic [7:0] PART = 8'h3c;  // Arbitrary part code.
  localparam logic [7:0] CONT = 8'hc3;  // Arbitrary continuation code.
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  fah_pkg::fah_op_t op_i = fah_pkg::FAH_OP_HV_READ;
  logic [1:0] code_sel_i = 2'h0;
  logic [8:0] sector_i = 9'h000;
  logic [20:0] wr_addr_i = 21'h000000;
  logic [7:0] wr_data_i = 8'h00;
  logic [8:0] stat_addr_i = 9'h000;
  logic stat_prot_o, busy_o, done_o, refused_o, all_prot_o, got_refuse;
  logic ce_n_o, oe_n_o, we_n_o, dq_oe_n_o, a9_hv_o, rst_hv_o;
  logic [7:0] rdata_o;
  logic [20:0] addr_o;
  logic [15:0] dq_i, dq_o;
  int fail_count = 0;
  int n_checks = 0;
  typedef struct {
    fah_pkg::fah_op_t op;
    logic [1:0] sel;
    logic [8:0] sect;
    logic [7:0] exp;
  } fah_row_t;
  // Code reads of both entry methods, the sector still unprotected.
  fah_row_t rows [8] = '{
    '{fah_pkg::FAH_OP_HV_READ, 2'h0, 9'h000, MAKER},
    '{fah_pkg::FAH_OP_HV_READ, 2'h1, 9'h1ff, PART},
    '{fah_pkg::FAH_OP_HV_READ, 2'h3, 9'h000, CONT},
    '{fah_pkg::FAH_OP_HV_READ, 2'h2, 9'h005, fah_pkg::PROT_NO},
    '{fah_pkg::FAH_OP_SYS_READ, 2'h0, 9'h000, MAKER},
    '{fah_pkg::FAH_OP_SYS_READ, 2'h1, 9'h000, PART},
    '{fah_pkg::FAH_OP_SYS_READ, 2'h3, 9'h000, CONT},
    '{fah_pkg::FAH_OP_SYS_READ, 2'h2, 9'h1ff, fah_pkg::PROT_NO}};
  always #4 ref_clk_i = ~ref_clk_i;
  fah_host dut (.*);
  fah_flash_model #(.MAKER(MAKER), .PART(PART), .CONT(CONT)) flash (
    .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o),
    .dq_i(dq_o), .a9_hv_i(a9_hv_o), .rst_hv_i(rst_hv_o), .dq_o(dq_i));
  // ---------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request, then a bounded wait for done or refusal.
  task automatic run_op(fah_pkg::fah_op_t op, logic [1:0] sel,
      logic [8:0] sect, logic [20:0] wa, logic [7:0] wd);
    int n;
    @(negedge ref_clk_i);
    op_i = op;
    code_sel_i = sel;
    sector_i = sect;
    wr_addr_i = wa;
    wr_data_i = wd;
    req_i = 1'b1;
    @(negedge ref_clk_i);
    req_i = 1'b0;
    for (n = 0; n < 20000; n++) begin
      if (done_o === 1'b1 || refused_o === 1'b1) break;
      @(negedge ref_clk_i);
    end
    got_refuse = refused_o;
    if (n == 20000) begin
      fail_count++;
      $display("Error done_o expected 1 seen timeout");
      give_verdict();
    end
  endtask
  // A write strobe must only fall with the gate high and select low.
  always @(negedge we_n_o) begin
    #1;
    if (rst_n_i) check("gate at write", 8'h02, {6'h0, oe_n_o, ce_n_o});
  end
  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    check("ce_n_o idle", 8'h01, {7'h00, ce_n_o});
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].sel, rows[i].sect, 21'h0, 8'h00);
      check("rdata_o", rows[i].exp, rdata_o);
      @(negedge ref_clk_i);
      check("a9_hv_o after", 8'h00, {7'h00, a9_hv_o});
      $display("row %0d done", i);
    end
    // Unprotect before all sectors are protected is refused.
    run_op(fah_pkg::FAH_OP_UNPROT_WR, 2'h0, 9'h0, 21'h0, 8'h00);
    check("refused_o", 8'h01, {7'h00, got_refuse});
    $display("early unprotect done");
    // Protect one sector; only that sector reads as protected.
    run_op(fah_pkg::FAH_OP_PROT_WR, 2'h0, 9'h0, 21'h005000, 8'h01);
    run_op(fah_pkg::FAH_OP_HV_READ, fah_pkg::CODE_PROT, 9'h005, 21'h0, 8'h00);
    check("prot 005", fah_pkg::PROT_YES, rdata_o);
    run_op(fah_pkg::FAH_OP_HV_READ, fah_pkg::CODE_PROT, 9'h006, 21'h0, 8'h00);
    check("prot 006", fah_pkg::PROT_NO, rdata_o);
    $display("protect done");
    // A scan with one protected sector leaves the all flag low.
    run_op(fah_pkg::FAH_OP_SCAN, 2'h0, 9'h0, 21'h0, 8'h00);
    check("all_prot_o", 8'h00, {7'h00, all_prot_o});
    stat_addr_i = 9'h005;
    repeat (2) @(negedge ref_clk_i);
    check("stat 005", 8'h01, {7'h00, stat_prot_o});
    stat_addr_i = 9'h006;
    repeat (2) @(negedge ref_clk_i);
    check("stat 006", 8'h00, {7'h00, stat_prot_o});
    $display("scan done");
    // A reset in mid-operation clears busy and the ninth line high voltage and raises select and write strobe.
    run_op(fah_pkg::FAH_OP_UNPROT_WR, 2'h0, 9'h0, 21'h0, 8'h00);
    check("refused_o again", 8'h01, {7'h00, got_refuse});
    @(negedge ref_clk_i);
    op_i = fah_pkg::FAH_OP_HV_READ;
    req_i = 1'b1;
    @(negedge ref_clk_i);
    req_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    check("pins in reset", 8'h03, {busy_o, a9_hv_o, ce_n_o, we_n_o});
    rst_n_i = 1'b1;
    run_op(fah_pkg::FAH_OP_HV_READ, 2'h0, 9'h0, 21'h0, 8'h00);
    check("rdata_o after reset", MAKER, rdata_o);
    $display("reset done");
    give_verdict();
  end
endmodule
